// >>> verilog/erf_pkg.sv
/*
 * Shared constants and types of the receive frame filter.
 * Assumes one 250 MHz clock and an AXI4-Lite register port.
 */
`default_nettype none

package erf_pkg;

   // ===================================================================
   // Register map
   localparam logic [7:0]  ADDR_FILTER_CFG = 8'h00;
   localparam logic [7:0]  ADDR_CTRL_ONE   = 8'h04;
   localparam logic [7:0]  ADDR_STA_LO     = 8'h08;
   localparam logic [7:0]  ADDR_STA_HI     = 8'h0c;
   localparam logic [7:0]  ADDR_STATS      = 8'h10;
   localparam logic [7:0]  ADDR_LAST       = 8'h14;

   // ===================================================================
   // Field positions and reset values
   localparam int unsigned CFG_W           = 10;
   localparam int unsigned BIT_RX_EN       = 8;
   localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
   localparam logic [47:0] STA_RESET       = 48'h0000_0000_0000;
   localparam logic [15:0] CNT_RESET       = 16'h0000;
   localparam logic [15:0] RUNT_MIN_BYTES  = 16'h0040;
   localparam logic [47:0] BCAST_ADDR      = 48'hffff_ffff_ffff;
   localparam int unsigned GROUP_BIT       = 40;

   // ===================================================================
   // Bus answers
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ===================================================================
   // Types
   typedef struct packed {
      logic wake_frame_filter_en;
      logic hash_filter_en;
      logic crc_error_collect_en;
      logic crc_valid_filter_en;
      logic runt_collect_en;
      logic runt_reject_en;
      logic own_unicast_accept_en;
      logic foreign_unicast_accept_en;
      logic group_addr_accept_en;
      logic all_stations_accept_en;
   } erf_cfg_t;

   typedef struct packed {
      logic        valid;
      logic [47:0] dst_addr;
      logic [15:0] byte_len;
      logic        crc_ok;
      logic        hash_hit;
      logic        magic_hit;
   } erf_frame_t;

   typedef struct packed {
      logic valid;
      logic accept;
      logic addr_match;
      logic crc_ok;
      logic runt;
      logic magic_hit;
      logic hash_hit;
   } erf_verdict_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'h1,
      WR_RESP    = 2'h2
   } erf_wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'h1,
      RD_DATA = 2'h2
   } erf_rd_state_t;

endpackage

`default_nettype wire

// >>> verilog/erf_classify.sv
/*
 * Combinational frame classifier: address, CRC and size checks.
 * Assumes a frame summary from the MAC on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module erf_classify (
   input  wire erf_pkg::erf_cfg_t     cfg,
   input  wire logic [47:0]           station_addr,
   input  wire erf_pkg::erf_frame_t   frame,
   output erf_pkg::erf_verdict_t      verdict
);

   logic short_len;
   logic addr_eq;
   logic bcast;
   logic mcast;
   logic ucast;
   logic runt_c;
   logic any_hit;
   logic gate_fail;

   // ===================================================================
   // Classification
   always_comb begin
      short_len = frame.byte_len < erf_pkg::RUNT_MIN_BYTES;
      addr_eq   = ~|(frame.dst_addr ^ station_addr); // see RULE10
      bcast     = frame.dst_addr == erf_pkg::BCAST_ADDR;
      mcast     = frame.dst_addr[erf_pkg::GROUP_BIT] & ~bcast;
      ucast     = ~frame.dst_addr[erf_pkg::GROUP_BIT];
      // Runt for collection depends on CRC filter setting
      runt_c    = short_len &
                  (~cfg.crc_valid_filter_en | frame.crc_ok); // see RULE4
      any_hit   = (cfg.own_unicast_accept_en & ucast & addr_eq) // see RULE6
                | (cfg.foreign_unicast_accept_en & ucast
                   & (addr_eq ^ 1'b1))       // see RULE7 see RULE10
                | (cfg.group_addr_accept_en & mcast)      // see RULE8
                | (cfg.all_stations_accept_en & bcast)    // see RULE9
                | (cfg.hash_filter_en & frame.hash_hit)
                | (cfg.wake_frame_filter_en & frame.magic_hit);
      gate_fail = (cfg.crc_error_collect_en & frame.crc_ok) // see RULE1
                | (cfg.crc_valid_filter_en & ~frame.crc_ok) // see RULE2
                | (cfg.runt_collect_en & ~runt_c)           // see RULE3
                | (cfg.runt_reject_en & short_len);         // see RULE5
      verdict.valid      = frame.valid;
      verdict.accept     = any_hit & ~gate_fail;            // see RULE14
      verdict.addr_match = addr_eq;
      verdict.crc_ok     = frame.crc_ok;
      verdict.runt       = short_len;
      // Matches reported whatever the enables say
      verdict.hash_hit   = frame.hash_hit;           // see RULE11
      verdict.magic_hit  = frame.magic_hit;          // see RULE12
   end

endmodule

`default_nettype wire

// >>> verilog/erf_rx_filter.sv
/*
 * Receive frame acceptance filter with AXI4-Lite register slave.
 * Assumes frame summaries from MAC logic on aclk, one per valid cycle.
 */
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE1 - CRC error collection: accept only bad CRC
// RULE2 - CRC valid filter: accept only good CRC
// RULE3 - Runt collection: accept only runt frames
// RULE4 - Collected runt needs good CRC if filtering
// RULE5 - Runt rejection refuses frames under 64 bytes
// RULE6 - Accept unicast matching station address
// RULE7 - Accept unicast not matching station address
// RULE8 - Accept all multicast frames when enabled
// RULE9 - Accept all broadcast frames when enabled
// RULE10 - Exclusive-or true for exactly one condition
// RULE11 - Hash match evaluated regardless of enable
// RULE12 - Magic match evaluated regardless of enable
// RULE13 - Software changes filter only with receive off
// RULE14 - Accept on any hit without gate failure
module erf_rx_filter (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire erf_pkg::erf_frame_t  frame_i,
   output erf_pkg::erf_verdict_t     verdict_q,
   output logic                      receive_enable_q
);

   // ===================================================================
   // Declarations
   erf_pkg::erf_wr_state_t wr_state_q;
   erf_pkg::erf_rd_state_t rd_state_q;
   logic [7:0]             awaddr_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;
   logic                   aw_have_q;
   logic                   w_have_q;
   logic [31:0]            cfg_reg_q;
   logic [47:0]            station_q;
   logic [15:0]            accept_cnt_q;
   logic [15:0]            drop_cnt_q;
   logic                   do_write;
   logic                   cfg_locked;
   logic                   stats_clr;
   erf_pkg::erf_cfg_t      cfg;
   erf_pkg::erf_verdict_t  verdict_d;
   logic                   frame_take;
   logic [7:0]             wr_word;
   logic [7:0]             rd_word;
   logic                   wr_refused;
   logic [31:0]            sta_hi_merged;

   // ===================================================================
   // Functions
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction
   function automatic logic [7:0] word_addr(input logic [7:0] a);
      return {a[7:2], 2'h0};
   endfunction
   function automatic logic addr_mapped(input logic [7:0] a);
      logic [7:0] w;
      w = word_addr(a);
      return (w == erf_pkg::ADDR_FILTER_CFG) || (w == erf_pkg::ADDR_CTRL_ONE)
          || (w == erf_pkg::ADDR_STA_LO) || (w == erf_pkg::ADDR_STA_HI)
          || (w == erf_pkg::ADDR_STATS) || (w == erf_pkg::ADDR_LAST);
   endfunction

   // ===================================================================
   // Classifier
   assign cfg = erf_pkg::erf_cfg_t'(cfg_reg_q[erf_pkg::CFG_W-1:0]);

   erf_classify u_classify (
      .cfg          (cfg),
      .station_addr (station_q),
      .frame        (frame_i),
      .verdict      (verdict_d)
   );

   // ===================================================================
   // Write channel
   assign wr_word    = word_addr(awaddr_q);
   assign rd_word    = word_addr(s_axi_araddr);
   assign do_write   = (wr_state_q == erf_pkg::WR_COLLECT)
                     & aw_have_q & w_have_q;
   assign cfg_locked = receive_enable_q;
   assign stats_clr  = do_write & (wr_word == erf_pkg::ADDR_STATS);
   assign wr_refused = !addr_mapped(awaddr_q)             // see RULE13
                     | (cfg_locked & (wr_word == erf_pkg::ADDR_FILTER_CFG));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         awaddr_q      <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_have_q     <= 1'b1;
         awaddr_q      <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
         aw_have_q     <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (!aw_have_q && wr_state_q == erf_pkg::WR_COLLECT) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q     <= 1'b0;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_have_q     <= 1'b1;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
         w_have_q     <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (!w_have_q && wr_state_q == erf_pkg::WR_COLLECT) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q   <= erf_pkg::WR_COLLECT;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= erf_pkg::RESP_OKAY;
      end else begin
         case (wr_state_q)
            erf_pkg::WR_COLLECT: begin
               if (do_write) begin
                  wr_state_q   <= erf_pkg::WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_refused ? erf_pkg::RESP_SLVERR
                                             : erf_pkg::RESP_OKAY;
               end
            end
            erf_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_q   <= erf_pkg::WR_COLLECT;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state_q   <= erf_pkg::WR_COLLECT;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // ===================================================================
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg_q <= erf_pkg::CFG_RESET;
      end else if (do_write && !cfg_locked && word_addr(awaddr_q)
                   == erf_pkg::ADDR_FILTER_CFG) begin
         cfg_reg_q <= merge_strb(cfg_reg_q, wdata_q, wstrb_q)
                    & 32'h0000_03ff; // see RULE13
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_enable_q <= 1'b0;
      end else if (do_write && wstrb_q[1] && word_addr(awaddr_q)
                   == erf_pkg::ADDR_CTRL_ONE) begin
         receive_enable_q <= wdata_q[erf_pkg::BIT_RX_EN];
      end
   end
   assign sta_hi_merged = merge_strb({16'h0000, station_q[47:32]}, wdata_q,
                                     wstrb_q);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         station_q <= erf_pkg::STA_RESET;
      end else if (do_write) begin
         if (word_addr(awaddr_q) == erf_pkg::ADDR_STA_LO) begin
            station_q[31:0] <= merge_strb(station_q[31:0], wdata_q, wstrb_q);
         end else if (word_addr(awaddr_q) == erf_pkg::ADDR_STA_HI) begin
            station_q[47:32] <= sta_hi_merged[15:0];
         end
      end
   end

   // ===================================================================
   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q    <= erf_pkg::RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= erf_pkg::RESP_OKAY;
      end else begin
         case (rd_state_q)
            erf_pkg::RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid & s_axi_arready) begin
                  rd_state_q    <= erf_pkg::RD_DATA;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rresp   <= erf_pkg::RESP_OKAY;
                  if (rd_word == erf_pkg::ADDR_FILTER_CFG) begin
                     s_axi_rdata <= cfg_reg_q;
                  end else if (rd_word == erf_pkg::ADDR_CTRL_ONE) begin
                     s_axi_rdata <= 32'(receive_enable_q) << erf_pkg::BIT_RX_EN;
                  end else if (rd_word == erf_pkg::ADDR_STA_LO) begin
                     s_axi_rdata <= station_q[31:0];
                  end else if (rd_word == erf_pkg::ADDR_STA_HI) begin
                     s_axi_rdata <= {16'h0000, station_q[47:32]};
                  end else if (rd_word == erf_pkg::ADDR_STATS) begin
                     s_axi_rdata <= {drop_cnt_q, accept_cnt_q};
                  end else if (rd_word == erf_pkg::ADDR_LAST) begin
                     s_axi_rdata <= {26'h0, verdict_q[5:0]};
                  end else begin
                     s_axi_rdata <= 32'h0000_0000;
                     s_axi_rresp <= erf_pkg::RESP_SLVERR;
                  end
               end
            end
            erf_pkg::RD_DATA: begin
               if (s_axi_rready) begin
                  rd_state_q    <= erf_pkg::RD_IDLE;
                  s_axi_rvalid  <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
            default: begin
               rd_state_q    <= erf_pkg::RD_IDLE;
               s_axi_rvalid  <= 1'b0;
               s_axi_arready <= 1'b0;
            end
         endcase
      end
   end

   // ===================================================================
   // Frame verdict
   assign frame_take = frame_i.valid & receive_enable_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         verdict_q <= '0;
      end else if (frame_take) begin
         verdict_q <= verdict_d; // see RULE14
      end else begin
         verdict_q.valid <= 1'b0;
      end
   end

   // A clear in the same cycle as a counted frame restarts the counter at one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accept_cnt_q <= erf_pkg::CNT_RESET;
      end else if (stats_clr) begin
         accept_cnt_q <= {15'h0000, frame_take & verdict_d.accept};
      end else if (frame_take & verdict_d.accept) begin
         accept_cnt_q <= accept_cnt_q + 16'h0001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drop_cnt_q <= erf_pkg::CNT_RESET;
      end else if (stats_clr) begin
         drop_cnt_q <= {15'h0000, frame_take & ~verdict_d.accept};
      end else if (frame_take & ~verdict_d.accept) begin
         drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
   end

   // ===================================================================
   // Assertions
   a_crc_err_collect: assert property ( // see RULE1
      @(posedge aclk) disable iff (!aresetn)
      (frame_take && cfg.crc_error_collect_en && frame_i.crc_ok)
      |=> (verdict_q.valid && !verdict_q.accept))
      else $error("bad crc collection verdict");
   a_crc_valid_gate: assert property ( // see RULE2
      @(posedge aclk) disable iff (!aresetn)
      (frame_take && cfg.crc_valid_filter_en && !frame_i.crc_ok)
      |=> (verdict_q.valid && !verdict_q.accept))
      else $error("bad crc frame accepted");
   a_runt_collect_only: assert property ( // see RULE3
      @(posedge aclk) disable iff (!aresetn)
      (verdict_q.valid && verdict_q.accept && $past(cfg.runt_collect_en))
      |-> verdict_q.runt)
      else $error("non runt collected");
   a_runt_crc_pair: assert property ( // see RULE4
      @(posedge aclk) disable iff (!aresetn)
      (verdict_q.valid && verdict_q.accept && $past(cfg.runt_collect_en)
       && $past(cfg.crc_valid_filter_en)) |-> verdict_q.crc_ok)
      else $error("runt with bad crc collected");
   a_runt_reject: assert property ( // see RULE5
      @(posedge aclk) disable iff (!aresetn)
      (frame_take && cfg.runt_reject_en
       && frame_i.byte_len < erf_pkg::RUNT_MIN_BYTES)
      |=> !verdict_q.accept)
      else $error("runt accepted under rejection");
   a_bcast_accept: assert property ( // see RULE9
      @(posedge aclk) disable iff (!aresetn)
      (frame_take && cfg == erf_pkg::erf_cfg_t'(10'h001)
       && frame_i.dst_addr == erf_pkg::BCAST_ADDR) |=> verdict_q.accept)
      else $error("broadcast frame dropped");
   a_own_ucast_hit: assert property ( // see RULE6
      @(posedge aclk) disable iff (!aresetn)
      (frame_take && cfg == erf_pkg::erf_cfg_t'(10'h008)
       && frame_i.dst_addr == station_q && !station_q[erf_pkg::GROUP_BIT])
      |=> (verdict_q.accept && verdict_q.addr_match))
      else $error("own unicast dropped");
   a_foreign_ucast: assert property ( // see RULE7 see RULE10
      @(posedge aclk) disable iff (!aresetn)
      (verdict_q.valid && verdict_q.accept
       && $past(cfg) == erf_pkg::erf_cfg_t'(10'h004))
      |-> !verdict_q.addr_match)
      else $error("foreign filter passed own address");
   a_hash_reported: assert property ( // see RULE11 see RULE12
      @(posedge aclk) disable iff (!aresetn)
      frame_take |=> (verdict_q.hash_hit == $past(frame_i.hash_hit)
                      && verdict_q.magic_hit == $past(frame_i.magic_hit)))
      else $error("match flags not reported");
   a_cfg_locked: assert property ( // see RULE13
      @(posedge aclk) disable iff (!aresetn)
      receive_enable_q |=> $stable(cfg_reg_q))
      else $error("filter changed while receiving");
   a_no_hit_drop: assert property ( // see RULE14
      @(posedge aclk) disable iff (!aresetn)
      (frame_take && cfg == erf_pkg::erf_cfg_t'(10'h000))
      |=> !verdict_q.accept)
      else $error("frame accepted with no criterion");
   a_write_answer: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid)
      else $error("write not answered");

endmodule

`default_nettype wire

// >>> sim/erf_mac_src.sv
/*
 * Model of the MAC receive datapath: sends frame summaries.
 * Assumes the filter samples frame_o on the rising edge of aclk.
 */
`timescale 1ns/100ps
`default_nettype none

module erf_mac_src (
   input  wire logic           aclk,
   output erf_pkg::erf_frame_t frame_o
);
   // ===================================================================
   // One-cycle summary, then idle with fields scrambled
   initial frame_o = '0;
   task automatic send(input logic [47:0] dst, input logic [15:0] len,
                       input logic crc, input logic hh, input logic mh);
      @(posedge aclk);
      frame_o <= erf_pkg::erf_frame_t'({1'b1, dst, len, crc, hh, mh});
      @(posedge aclk);
      frame_o <= erf_pkg::erf_frame_t'({1'b0, ~frame_o[66:0]});
   endtask
endmodule

`default_nettype wire

// >>> sim/erf_rx_filter_tb.sv
/*
 * Self-checking bench of the receive frame filter.
 * Assumes erf_pkg and the MAC model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module erf_rx_filter_tb;
   logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr, arr, ren;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd;
   logic [1:0]  bresp, rresp, resp;
   erf_pkg::erf_frame_t   frm;
   erf_pkg::erf_verdict_t vd;
   int miscompares = 0;
   int tests_run = 0;
   localparam logic [47:0] STA = 48'h0222_3344_5566;
   localparam logic [47:0] OTH = 48'h0222_3344_5567;
   localparam logic [47:0] MCA = 48'h0100_5e00_0001;
   localparam logic [47:0] BCA = erf_pkg::BCAST_ADDR;

   erf_rx_filter u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .frame_i(frm),
      .verdict_q(vd), .receive_enable_q(ren));
   erf_mac_src u_src (.aclk(aclk), .frame_o(frm));

   // ===================================================================
   // Clock, reset, watchdog
   initial begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      aresetn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
      awa = '0; ara = '0; wd = '0;
   end
   initial begin
      repeat (30000) @(posedge aclk);
      miscompares++;
      summarize();
   end

   // ===================================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
      end while (!bv);
      resp = bresp;
      br <= 0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      ara <= a; arv <= 1; rr <= 1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 0;
      end while (!rv);
      d = rd;
      resp = rresp;
      rr <= 0;
   endtask
   task automatic set_cfg(input logic [31:0] c);
      axw(erf_pkg::ADDR_CTRL_ONE, 32'h0);
      axw(erf_pkg::ADDR_FILTER_CFG, c);
      chk("cfg_resp", resp, erf_pkg::RESP_OKAY);
      axw(erf_pkg::ADDR_CTRL_ONE, 32'h100);
      chk("rx_en", ren, 1'b1);
   endtask
   task automatic fr(input logic [31:0] c, input logic [47:0] dst,
                     input logic [15:0] len, input logic crc, hh, mh, acc);
      set_cfg(c);
      u_src.send(dst, len, crc, hh, mh);
      #1;
      chk("vld", vd.valid, 1'b1);
      chk("accept", vd.accept, acc);
      chk("crc_ok", vd.crc_ok, crc);
      chk("hash", vd.hash_hit, hh);
      chk("magic", vd.magic_hit, mh);
      chk("runt", vd.runt, len < erf_pkg::RUNT_MIN_BYTES);
      chk("match", vd.addr_match, dst == STA);
   endtask

   // ===================================================================
   // Scenarios
   task automatic t_regs();
      logic [31:0] d;
      axr(erf_pkg::ADDR_FILTER_CFG, d);
      chk("cfg_rst", d, erf_pkg::CFG_RESET);
      axr(8'h18, d);
      chk("unmap_rd", resp, erf_pkg::RESP_SLVERR);
      axw(8'h18, 32'hffff_ffff);
      chk("unmap_wr", resp, erf_pkg::RESP_SLVERR);
      axw(erf_pkg::ADDR_STA_LO, STA[31:0]);
      axw(erf_pkg::ADDR_STA_HI, {16'h0, STA[47:32]});
      axr(erf_pkg::ADDR_STA_HI, d);
      chk("sta_hi", d, {16'h0, STA[47:32]});
   endtask
   task automatic t_locked();
      logic [31:0] d;
      set_cfg(32'h001);
      axw(erf_pkg::ADDR_FILTER_CFG, 32'h3ff);
      chk("lock_resp", resp, erf_pkg::RESP_SLVERR);
      axr(erf_pkg::ADDR_FILTER_CFG, d);
      chk("lock_cfg", d, 32'h001);
      axw(erf_pkg::ADDR_CTRL_ONE, 32'h0);
      u_src.send(BCA, 16'd100, 1'b1, 1'b0, 1'b0);
      #1;
      chk("rx_off", vd.valid, 1'b0);
   endtask
   task automatic t_stats();
      logic [31:0] d;
      axr(erf_pkg::ADDR_STATS, d);
      chk("stats", d, 32'h0009_000b);
      axr(erf_pkg::ADDR_LAST, d);
      chk("last", d, 32'h0000_002a);
      axw(erf_pkg::ADDR_STATS, 32'h0);
      chk("clr_resp", resp, erf_pkg::RESP_OKAY);
      axr(erf_pkg::ADDR_STATS, d);
      chk("stats_clr", d, 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      t_regs();
      t_locked();
      fr(32'h008, STA, 16'd100, 1, 0, 0, 1);
      fr(32'h008, OTH, 16'd100, 1, 0, 0, 0);
      fr(32'h004, OTH, 16'd100, 1, 0, 0, 1);
      fr(32'h004, STA, 16'd100, 1, 0, 0, 0);
      fr(32'h002, MCA, 16'd100, 1, 0, 0, 1);
      fr(32'h002, BCA, 16'd100, 1, 0, 0, 0);
      fr(32'h001, BCA, 16'd100, 1, 0, 0, 1);
      fr(32'h081, BCA, 16'd100, 1, 0, 0, 0);
      fr(32'h081, BCA, 16'd100, 0, 0, 0, 1);
      fr(32'h041, BCA, 16'd100, 0, 0, 0, 0);
      fr(32'h021, BCA, 16'd63, 0, 0, 0, 1);
      fr(32'h021, BCA, 16'd64, 1, 0, 0, 0);
      fr(32'h061, BCA, 16'd63, 0, 0, 0, 0);
      fr(32'h061, BCA, 16'd63, 1, 0, 0, 1);
      fr(32'h011, BCA, 16'd63, 1, 0, 0, 0);
      fr(32'h011, BCA, 16'd64, 1, 0, 0, 1);
      fr(32'h00c, OTH, 16'd100, 1, 0, 0, 1);
      fr(32'h000, OTH, 16'd100, 1, 1, 1, 0);
      fr(32'h100, OTH, 16'd100, 1, 1, 0, 1);
      fr(32'h200, OTH, 16'd100, 1, 0, 1, 1);
      t_stats();
      summarize();
   end
endmodule

`default_nettype wire
